// ---- rtl/time_base_defs.svh ----
// constants for the time base and square-wave output block
`ifndef TIME_BASE_DEFS_SVH
`define TIME_BASE_DEFS_SVH

// register indices; byte address is four times the index
`define TB_CTRL_IDX      8'h36
`define TB_STATUS_IDX    8'h37
`define TB_MASK_IDX      8'h38
`define TB_COUNT_IDX     8'h39
`define TB_ADDR_W        12
`define TB_CTRL_ADDR     {2'b00, `TB_CTRL_IDX, 2'b00}
`define TB_STATUS_ADDR   {2'b00, `TB_STATUS_IDX, 2'b00}
`define TB_MASK_ADDR     {2'b00, `TB_MASK_IDX, 2'b00}
`define TB_COUNT_ADDR    {2'b00, `TB_COUNT_IDX, 2'b00}

// control register fields
`define TB_SQ_EN_BIT     7
`define TB_SQ_RATE_HI    6
`define TB_SQ_RATE_LO    5
`define TB_IRQ_EN_BIT    3
`define TB_IRQ_RATE_HI   2
`define TB_IRQ_RATE_LO   0
`define TB_CTRL_RESET    8'h00
`define TB_EVT_RESET     2'h0

// status and mask fields
`define TB_EVT_TICK_BIT  0
`define TB_EVT_SQ_BIT    1

// prescaler and its taps: divide by 2^n falls on bit n-1
`define TB_PRE_W         23
`define TB_TAP_D23       5'h16
`define TB_TAP_D21       5'h14
`define TB_TAP_D16       5'h0F
`define TB_TAP_D14       5'h0D
`define TB_TAP_D13       5'h0C
`define TB_TAP_D12       5'h0B
`define TB_TAP_D11       5'h0A
`define TB_TAP_D9        5'h08
`define TB_SQTAP_D13     5'h0C
`define TB_SQTAP_D12     5'h0B
`define TB_SQTAP_D11     5'h0A
`define TB_SQTAP_D10     5'h09

`endif

// ---- rtl/time_base_pkg.sv ----
// types shared by the time base block
package time_base_pkg;

  typedef struct packed {
    logic       sq_en;
    logic [1:0] sq_rate;
    logic       rsvd;
    logic       irq_en;
    logic [2:0] irq_rate;
  } ctrl_s;

  typedef struct packed {
    logic sq_edge;
    logic tick;
  } evt_s;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_ACCESS = 2'b01
  } bus_state_e;

endpackage

// ---- rtl/time_base_unit.sv ----
// time base timer, periodic interrupt and square-wave output with APB slave
// Function
// - 8-bit control register, all bits reset zero
// - interrupt rate code picks divider 2^23..2^9
// - code 000 about 0.95 Hz, 111 fast
// - rate and enable written together start new rate
// - request on each falling edge of tap
// - writes never clear the prescaler
// - square wave about 50% duty when enabled
// - square wave on active-low output pin
// - square rate codes double frequency each step
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "time_base_defs.svh"

// falling edge of one prescaler bit, seen from the count and its successor;
// purely combinational so the caller decides where to register it
module tap_fall_detect #(
  parameter int W = 23
) (
  input  wire logic [W-1:0] cnt,
  input  wire logic [W-1:0] cnt_nxt,
  input  wire logic [4:0]   sel,
  input  wire logic         en,
  output logic              fall
);
  assign fall = en & cnt[sel] & ~cnt_nxt[sel];
endmodule // tap_fall_detect

module time_base_unit (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`TB_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        periodic_irq_request,
  output logic                        square_out_n,
  output logic                        irq
);
  import time_base_pkg::*;

  ctrl_s                 ctrl_r;
  evt_s                  status_r;
  evt_s                  status_nxt;
  evt_s                  mask_r;
  evt_s                  evt;
  bus_state_e            bus_r;
  logic [`TB_PRE_W-1:0]  pre_r;
  logic [`TB_PRE_W-1:0]  pre_nxt;
  logic [4:0]            irq_tap;
  logic [4:0]            sq_tap;
  logic                  tick;
  logic                  sq_fall;
  logic [31:0]           prdata_r;
  logic                  pready_r;
  logic                  pslverr_r;
  logic                  req_r;
  logic                  sq_r;
  logic                  irq_r;
  logic                  wr_take;
  logic                  mapped;
  logic [31:0]           rd_val;
  logic                  setup;

  // free-running prescaler, only reset clears it;
  // control writes never touch it, so the first tick after
  // enabling may come early, a limitation software must accept
  // 23 bits cover the slowest divider, 2^23
  assign pre_nxt = pre_r + `TB_PRE_W'(1);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // interrupt tap select from the rate code
  // division by 2^(k+1) falls on bit k of the count
  always_comb begin
    case (ctrl_r.irq_rate)
      3'b000:  irq_tap = `TB_TAP_D23;
      3'b001:  irq_tap = `TB_TAP_D21;
      3'b010:  irq_tap = `TB_TAP_D16;
      3'b011:  irq_tap = `TB_TAP_D14;
      3'b100:  irq_tap = `TB_TAP_D13;
      3'b101:  irq_tap = `TB_TAP_D12;
      3'b110:  irq_tap = `TB_TAP_D11;
      3'b111:  irq_tap = `TB_TAP_D9;
      default: irq_tap = `TB_TAP_D23;
    endcase
  end

  // square-wave tap select; each step halves the divider
  always_comb begin
    case (ctrl_r.sq_rate)
      2'b00:   sq_tap = `TB_SQTAP_D13;
      2'b01:   sq_tap = `TB_SQTAP_D12;
      2'b10:   sq_tap = `TB_SQTAP_D11;
      2'b11:   sq_tap = `TB_SQTAP_D10;
      default: sq_tap = `TB_SQTAP_D13;
    endcase
  end

  // interrupt tick on the falling edge of the selected tap;
  // no history flop, so a rate change lands on the new tap at once
  tap_fall_detect #(
    .W (`TB_PRE_W)
  ) u_tap_fall_detect_irq (
    .cnt     (pre_r),
    .cnt_nxt (pre_nxt),
    .sel     (irq_tap),
    .en      (ctrl_r.irq_en),
    .fall    (tick)
  );

  // falling tap edge of the square wave, logged in status
  tap_fall_detect #(
    .W (`TB_PRE_W)
  ) u_tap_fall_detect_sq (
    .cnt     (pre_r),
    .cnt_nxt (pre_nxt),
    .sel     (sq_tap),
    .en      (ctrl_r.sq_en),
    .fall    (sq_fall)
  );

  // request pulse, coincides with the falling tap edge;
  // registered, so it lands in the cycle where the tap bits read zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      req_r <= 1'b0;
    end else begin
      req_r <= tick;
    end
  end

  // pin is the inverted tap; idle level is high
  // registered in step with the count, so duty is exactly half
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sq_r <= 1'b1;
    end else if (ctrl_r.sq_en) begin
      sq_r <= ~pre_nxt[sq_tap];
    end else begin
      sq_r <= 1'b1;
    end
  end

  // bus decode; four word registers, anything else answers pslverr
  assign mapped  = (paddr == `TB_CTRL_ADDR) || (paddr == `TB_STATUS_ADDR) ||
                   (paddr == `TB_MASK_ADDR) || (paddr == `TB_COUNT_ADDR);
  // writes commit in the access cycle, as pready is seen high
  assign wr_take = psel & penable & pready_r & pwrite & ~pslverr_r;
  // setup phase seen while no access is in flight
  assign setup   = (bus_r == BUS_IDLE) & psel & ~penable;

  // read mux; unused high bits read as zero
  // count reads the prescaler as it stood in the setup cycle
  always_comb begin
    rd_val = '0;
    if (paddr == `TB_CTRL_ADDR) begin
      rd_val[7:0] = {ctrl_r.sq_en, ctrl_r.sq_rate, 1'b0,
                     ctrl_r.irq_en, ctrl_r.irq_rate};
    end else if (paddr == `TB_STATUS_ADDR) begin
      rd_val[1:0] = status_r;
    end else if (paddr == `TB_MASK_ADDR) begin
      rd_val[1:0] = mask_r;
    end else if (paddr == `TB_COUNT_ADDR) begin
      rd_val[`TB_PRE_W-1:0] = pre_r;
    end
  end

  // bus phase: setup moves to access, access always lasts one cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bus_r <= BUS_IDLE;
    end else begin
      case (bus_r)
        BUS_IDLE: begin
          if (psel && !penable) begin
            bus_r <= BUS_ACCESS;
          end
        end
        BUS_ACCESS: begin
          bus_r <= BUS_IDLE;
        end
        default: begin
          bus_r <= BUS_IDLE;
        end
      endcase
    end
  end

  // zero wait states: pready stands for exactly the access cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  // error flag rides with pready for an unmapped address
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= setup & ~mapped;
    end
  end

  // read data stands only with pready and reads zero otherwise,
  // so a stale word never lingers on a shared read bus
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata_r <= '0;
    end else if (setup && !pwrite && mapped) begin
      prdata_r <= rd_val;
    end else begin
      prdata_r <= 32'h0000_0000;
    end
  end

  // control register; software alone keeps rate fields stable
  // while enabled, the hardware does not police it
  // reserved bit 4 is stored as zero and reads zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `TB_CTRL_RESET;
    end else if (wr_take && paddr == `TB_CTRL_ADDR) begin
      ctrl_r.sq_en    <= pwdata[`TB_SQ_EN_BIT];
      ctrl_r.sq_rate  <= pwdata[`TB_SQ_RATE_HI:`TB_SQ_RATE_LO];
      ctrl_r.rsvd     <= 1'b0;
      ctrl_r.irq_en   <= pwdata[`TB_IRQ_EN_BIT];
      ctrl_r.irq_rate <= pwdata[`TB_IRQ_RATE_HI:`TB_IRQ_RATE_LO];
    end
  end

  // mask register; gates the level interrupt only, status still records
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mask_r <= `TB_EVT_RESET;
    end else if (wr_take && paddr == `TB_MASK_ADDR) begin
      mask_r <= pwdata[1:0];
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  // both events share one word so a single read sees them together
  assign evt = {sq_fall, tick};

  always_comb begin
    status_nxt = status_r;
    if (wr_take && paddr == `TB_STATUS_ADDR) begin
      status_nxt = status_nxt & ~evt_s'(pwdata[1:0]);
    end
    status_nxt = status_nxt | evt;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status_r <= `TB_EVT_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // level interrupt from the next status so it tracks without lag;
  // a mask write shows on irq one cycle after it commits
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // every output comes straight from its flop
  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign periodic_irq_request = req_r;
  assign square_out_n         = sq_r;
  assign irq                  = irq_r;

endmodule // time_base_unit

// ---- tb/time_base_assertions.sv ----
// assertion checker for the time base block
`timescale 1ns/1ps
`include "time_base_defs.svh"
module time_base_checker (
  input wire logic                  core_clk,
  input wire logic                  reset,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [`TB_ADDR_W-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  periodic_irq_request,
  input wire logic                  square_out_n,
  input wire logic                  irq
);
  localparam int TK[8] = '{22, 20, 15, 13, 12, 11, 10, 8};
  logic [22:0] cnt_r;
  logic [22:0] imask;
  logic [7:0]  ctl_r;
  logic        msk_r;
  logic        wr_ok;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign imask = 23'((24'h2 << TK[ctl_r[2:0]]) - 24'h1);
  // shadow prescaler and registers; writes never clear the count
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 23'h0;
      ctl_r <= 8'h00;
      msk_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 23'h1;
      if (wr_ok && paddr == `TB_CTRL_ADDR) ctl_r <= pwdata[7:0];
      if (wr_ok && paddr == `TB_MASK_ADDR) msk_r <= pwdata[0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready late");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("stray pslverr");
  rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  sq_idle_high_a: assert property (!ctl_r[7] && $stable(ctl_r) |-> square_out_n)
    else $error("pin low while off");
  sq_phase_a: assert property (ctl_r[7] && $stable(ctl_r)
    |-> square_out_n == !cnt_r[12 - ctl_r[6:5]]) else $error("square phase");
  tick_on_tap_a: assert property (periodic_irq_request |-> (cnt_r & imask) == 0)
    else $error("tick off tap");
  tick_when_due_a: assert property (ctl_r[3] && $stable(ctl_r)
    && (cnt_r & imask) == 0 |-> periodic_irq_request) else $error("tick missed");
  irq_follows_tick_a: assert property (periodic_irq_request && msk_r |-> irq)
    else $error("irq not raised");
  cover property (periodic_irq_request && irq);
  cover property (pslverr);
  cover property (ctl_r[7] && $fell(square_out_n));
endmodule // time_base_checker

bind time_base_unit time_base_checker u_time_base_checker (.core_clk(core_clk),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .periodic_irq_request(periodic_irq_request), .square_out_n(square_out_n), .irq(irq));

// ---- tb/buzzer_model.sv ----
// buzzer on the square output: times its active-low drive
`timescale 1ns/1ps
module buzzer_model (
  input wire logic core_clk,
  input wire logic square_out_n,
  output int       period,
  output int       low_time,
  output int       falls
);
  int   cnt = 0;
  int   lo = 0;
  logic prev = 1'b1;
  // one period runs from a falling edge to the next
  always @(posedge core_clk) begin
    prev <= square_out_n;
    cnt <= cnt + 1;
    lo <= lo + (square_out_n ? 0 : 1);
    if (prev && !square_out_n) begin
      period <= cnt;
      low_time <= lo;
      falls <= falls + 1;
      cnt <= 1;
      lo <= 1;
    end
  end
endmodule // buzzer_model

// ---- tb/time_base_unit_tb.sv ----
// self-checking bench for the time base block
`timescale 1ns/1ps
`include "time_base_defs.svh"
module time_base_unit_tb;
  logic        core_clk = 1'b0;
  logic        reset, psel, penable, pwrite, pready, pslverr, err;
  logic        periodic_irq_request, square_out_n, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, c0;
  int          n_errors = 0, cmp_count = 0, cyc = 0, per, low, falls, f;
  int          cd[3] = '{7, 6, 5};
  int          pr[3] = '{512, 2048, 4096};

  time_base_unit u_time_base_unit (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periodic_irq_request(periodic_irq_request),
    .square_out_n(square_out_n), .irq(irq));
  buzzer_model u_buzzer_model (.core_clk(core_clk), .square_out_n(square_out_n),
    .period(per), .low_time(low), .falls(falls));

  // 10 MHz clock; the cycle count also cuts a hang short
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %0t got %0h want %0h", $time, got, exp);
    end
  endtask

  // apb transfer: held until pready is seen at an edge, released after
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tick_wait();
    do @(posedge core_clk); while (periodic_irq_request !== 1'b1);
  endtask

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    xfer(1'b0, `TB_CTRL_ADDR, 32'h0);
    chk(rdata, 32'h0);
    xfer(1'b1, `TB_CTRL_ADDR, 32'h77);
    xfer(1'b0, `TB_CTRL_ADDR, 32'h0);
    chk(rdata, 32'h67);
    xfer(1'b0, 12'h000, 32'h0);
    chk(32'(err), 32'h1);
    chk(rdata, 32'h0);
    // a control write between two reads must not disturb the count
    xfer(1'b0, `TB_COUNT_ADDR, 32'h0);
    c0 = rdata;
    xfer(1'b1, `TB_CTRL_ADDR, 32'h07);
    xfer(1'b0, `TB_COUNT_ADDR, 32'h0);
    chk(rdata - c0, 32'h6);
    // rate set while off, then rate and enable together
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, `TB_CTRL_ADDR, 32'(cd[i]));
      xfer(1'b1, `TB_CTRL_ADDR, 32'(cd[i] + 8));
      tick_wait();
      f = cyc;
      tick_wait();
      chk(32'(cyc - f), 32'(pr[i]));
      xfer(1'b1, `TB_CTRL_ADDR, 32'(cd[i]));
    end
    // new rate and enable in one write, then masked event, unmask, clear
    xfer(1'b1, `TB_CTRL_ADDR, 32'h0F);
    tick_wait();
    f = cyc;
    tick_wait();
    chk(32'(cyc - f), 32'h200);
    @(posedge core_clk);
    chk(32'(irq), 32'h0);
    xfer(1'b0, `TB_STATUS_ADDR, 32'h0);
    chk(rdata, 32'h1);
    xfer(1'b1, `TB_MASK_ADDR, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h1);
    xfer(1'b1, `TB_CTRL_ADDR, 32'h07);
    xfer(1'b1, `TB_STATUS_ADDR, 32'h1);
    xfer(1'b0, `TB_STATUS_ADDR, 32'h0);
    chk(rdata, 32'h0);
    chk(32'(irq), 32'h0);
    // each square rate code halves the period; the first fall after
    // enabling may be cut short, so the third one closes a full period
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, `TB_CTRL_ADDR, 32'(c << 5));
      xfer(1'b1, `TB_CTRL_ADDR, 32'(8'h80 + (c << 5)));
      f = falls;
      while (falls < f + 3) @(posedge core_clk);
      chk(32'(per), 32'(8192 >> c));
      chk(32'(low), 32'(4096 >> c));
      xfer(1'b1, `TB_CTRL_ADDR, 32'(c << 5));
    end
    f = falls;
    repeat (9000) @(posedge core_clk);
    chk(32'(falls - f), 32'h0);
    chk(32'(square_out_n), 32'h1);
    // square edges logged but masked off; tick bit stays clear
    xfer(1'b0, `TB_STATUS_ADDR, 32'h0);
    chk(rdata, 32'h2);
    chk(32'(irq), 32'h0);
    finish_test();
  end
endmodule // time_base_unit_tb
